// ===== hdl/bps_pkg.sv
package bps_pkg;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int unsigned CLK_SYS_MHZ     = 250;
  localparam int unsigned PG_GOOD_TIME_MS = 10;
  localparam int unsigned PG_BAD_TIME_NS  = 2000;
  // longest-time style counts round down, least-time round up
  localparam int unsigned PG_GOOD_CYCLES  =
    PG_GOOD_TIME_MS * 1000 * CLK_SYS_MHZ;
  localparam int unsigned PG_BAD_CYCLES   =
    (PG_BAD_TIME_NS * CLK_SYS_MHZ + 999) / 1000;
  localparam int unsigned INT_OSC_KHZ     = 2100;
  localparam int unsigned OSC_HALF_CYCLES =
    (CLK_SYS_MHZ * 1000) / (2 * INT_OSC_KHZ);

  // ********************************************************
  // overcurrent and retry sequence
  // ********************************************************
  localparam logic [2:0] OC_STEP_COUNT    = 3'h2;
  localparam logic [2:0] OC_HICCUP_COUNT  = 3'h6;
  localparam logic [2:0] HICCUP_WINDOW    = 3'h6;
  localparam logic [5:0] SS_GROUND_CYCLES = 6'h20;
  localparam int unsigned OFF_TO_SS_RATIO = 12;
  localparam int unsigned SS_CHARGE_UA_X10  = 300;
  localparam int unsigned SS_DISCH_UA_X10   = 15;

  typedef enum {
    BPS_OFF,
    BPS_SOFT_START,
    BPS_RUN,
    BPS_HICCUP_OFF,
    BPS_SS_GROUND
  } bps_state_type;

  // analog comparator outputs, asynchronous to clk_sys
  typedef struct packed {
    logic enable;
    logic vin_ok;
    logic vin_discharge_ok;
    logic overtemp;
    logic overvoltage;
    logic overcurrent;
    logic out_in_window;
    logic out_below_half;
    logic ss_done;
    logic ss_at_low;
  } bps_cond_type;

  // gate and analog control outputs
  typedef struct packed {
    logic high_side_on;
    logic low_side_on;
    logic converter_on;
    logic ss_charge;
    logic ss_discharge_slow;
    logic ss_ground;
    logic oc_level_reduced;
    logic output_discharge;
  } bps_drive_type;

endpackage : bps_pkg

// ===== hdl/bps_sequencer.sv
// Overview of operation
// - switching cycle starts on sync input fall
// - sync held high stops switching
// - sync output is inverted internal clock
// - sync output inverts followed external clock
// - power-good released after 10ms in window
// - power-good pulled down after 2us outside
// - power-good pulled down off and soft start
// - overvoltage: high side off, low on
// - input undervoltage: converter and switches off
// - overcurrent: high side off, low on
// - two overcurrent cycles reduce trip to 75%
// - six overcurrent cycles below half: retry
// - non-overcurrent cycle clears the count
// - retry off phase slowly discharges soft-start
// - at 0.52V ground 32 cycles, restart
// - no retry entry during soft start
// - retry checked six periods after soft start
// - off phase about twelve charge times
// - overtemperature shuts off, restarts soft start
// - discharge switch on when disabled, vin>=3V
// - enable with good input starts soft start
`timescale 1ns/1ns
`default_nettype none
module bps_sequencer #(
  parameter int unsigned PG_GOOD_CYCLES_P = bps_pkg::PG_GOOD_CYCLES
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire bps_pkg::bps_cond_type cond_in,
  input  wire logic                  sync_clock_in,
  input  wire logic                  sync_detect,
  input  wire logic                  pwm_reset,
  output var  logic                  sync_clock_out,
  output var  logic                  power_good_pulldown,
  output var  logic                  power_good_pin_oe,
  output var  logic                  power_good_pin_out,
  output var  logic                  cycle_start,
  output var  bps_pkg::bps_drive_type drive
);
  import bps_pkg::*;

  // ********************************************************
  // synchronisers
  // ********************************************************
  localparam int unsigned SW = $bits(bps_cond_type) + 2;

  logic [SW-1:0] sync_q;
  bps_cond_type  cond;
  logic          ext_clk;
  logic          ext_sel;

  bps_sync #(
    .WIDTH (SW)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({cond_in, sync_clock_in, sync_detect}),
    .sync_out (sync_q)
  );

  assign cond    = sync_q[SW-1:2];
  assign ext_clk = sync_q[1];
  assign ext_sel = sync_q[0];

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    bps_state_type seq;
    logic [15:0]   osc_cnt;
    logic          osc_clk;
    logic          ext_prev;
    logic          clk_prev;
    logic          sel_prev;
    logic          cycle;
    logic          on_phase;
    logic          oc_seen;
    logic [2:0]    oc_cnt;
    logic [2:0]    oc_run;
    logic [2:0]    win_cnt;
    logic          win_open;
    logic [5:0]    gnd_cnt;
    logic [31:0]   ss_cnt;
    logic [31:0]   off_cnt;
    logic [31:0]   pg_cnt;
    logic          pg_down;
    logic          pg_pin_out;
    logic          sync_out;
    bps_drive_type drv;
  } bps_core_type;

  bps_core_type s_r;
  bps_core_type s_nxt;

  logic sw_clk;
  logic sw_fall;
  logic osc_fall;
  logic run_ok;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.cycle = 1'b0;

    // ******************************************************
    // switching clock
    // ******************************************************
    // internal oscillator free-runs; external clock wins when present
    osc_fall = 1'b0;
    if (s_r.osc_cnt >= 16'(OSC_HALF_CYCLES - 1)) begin
      s_nxt.osc_cnt = '0;
      s_nxt.osc_clk = ~s_r.osc_clk;
      osc_fall      = s_r.osc_clk;
    end else begin
      s_nxt.osc_cnt = s_r.osc_cnt + 16'h0001;
    end
    sw_clk         = ext_sel ? ext_clk : s_r.osc_clk;
    s_nxt.clk_prev = sw_clk;
    s_nxt.sel_prev = ext_sel;
    // a held-high external clock never falls: no cycles
    // a change of source is no fall: no runt cycle at the switch
    sw_fall        = s_r.clk_prev & ~sw_clk &
                     (ext_sel == s_r.sel_prev);
    s_nxt.sync_out = ~sw_clk;

    run_ok = cond.vin_ok & cond.enable & ~cond.overtemp;

    // ******************************************************
    // sequencer
    // ******************************************************
    unique case (s_r.seq)
      BPS_OFF: begin
        if (run_ok) begin
          s_nxt.seq    = BPS_SOFT_START;
          s_nxt.ss_cnt = '0;
        end
      end
      BPS_SOFT_START: begin
        s_nxt.ss_cnt = s_r.ss_cnt + 32'h1;
        if (cond.ss_done) begin
          s_nxt.seq      = BPS_RUN;
          s_nxt.win_open = 1'b1;
          s_nxt.win_cnt  = '0;
        end
      end
      BPS_RUN: begin
      end
      BPS_HICCUP_OFF: begin
        s_nxt.off_cnt = s_r.off_cnt + 32'h1;
        if (cond.ss_at_low) begin
          s_nxt.seq     = BPS_SS_GROUND;
          s_nxt.gnd_cnt = '0;
        end
      end
      BPS_SS_GROUND: begin
        // counted on the internal clock, even while following
        if (osc_fall) begin
          s_nxt.gnd_cnt = s_r.gnd_cnt + 6'h01;
          if (s_r.gnd_cnt == SS_GROUND_CYCLES - 6'h01) begin
            s_nxt.seq    = BPS_SOFT_START;
            s_nxt.ss_cnt = '0;
          end
        end
      end
    endcase

    // ******************************************************
    // per-cycle overcurrent bookkeeping
    // ******************************************************
    if (sw_fall) begin
      s_nxt.cycle    = (s_r.seq == BPS_SOFT_START) || (s_r.seq == BPS_RUN);
      s_nxt.on_phase = s_nxt.cycle;
      s_nxt.oc_seen  = 1'b0;
      if (s_r.oc_seen && cond.out_below_half) begin
        if (s_r.oc_cnt != 3'h7) begin
          s_nxt.oc_cnt = s_r.oc_cnt + 3'h1;
        end
      end else begin
        s_nxt.oc_cnt = '0;
      end
      // the step-down counts every overcurrent cycle
      if (s_r.oc_seen) begin
        if (s_r.oc_run != 3'h7) begin
          s_nxt.oc_run = s_r.oc_run + 3'h1;
        end
      end else begin
        s_nxt.oc_run = '0;
      end
      if (s_r.win_open) begin
        s_nxt.win_cnt = s_r.win_cnt + 3'h1;
        if (s_r.win_cnt == HICCUP_WINDOW - 3'h1) begin
          s_nxt.win_open = 1'b0;
        end
      end
    end
    if (cond.overcurrent) begin
      s_nxt.oc_seen  = 1'b1;
      s_nxt.on_phase = 1'b0;
    end
    // loop comparator ends the on phase for the rest of the cycle
    if (pwm_reset) begin
      s_nxt.on_phase = 1'b0;
    end
    // two-cycle step-down uses any overcurrent, not the half-output test
    s_nxt.drv.oc_level_reduced = (s_r.oc_run >= OC_STEP_COUNT) ||
      (s_r.oc_seen && s_r.drv.oc_level_reduced);

    // ******************************************************
    // retry entry
    // ******************************************************
    // only in run, only inside the window after soft start
    if (s_r.seq == BPS_RUN && s_r.win_open &&
        s_r.oc_cnt >= OC_HICCUP_COUNT) begin
      s_nxt.seq     = BPS_HICCUP_OFF;
      s_nxt.off_cnt = '0;
    end

    // ******************************************************
    // shutdown
    // ******************************************************
    // shutdown paths override everything
    if (!run_ok) begin
      s_nxt.seq      = BPS_OFF;
      s_nxt.on_phase = 1'b0;
      s_nxt.oc_cnt   = '0;
      s_nxt.oc_run   = '0;
      s_nxt.win_open = 1'b0;
    end

    // ******************************************************
    // gate drive
    // ******************************************************
    s_nxt.drv.converter_on = run_ok;
    if (!run_ok) begin
      s_nxt.drv.high_side_on = 1'b0;
      s_nxt.drv.low_side_on  = 1'b0;
    end else if (cond.overvoltage) begin
      s_nxt.drv.high_side_on = 1'b0;
      s_nxt.drv.low_side_on  = 1'b1;
    end else if (s_nxt.seq == BPS_SOFT_START ||
                 s_nxt.seq == BPS_RUN) begin
      // overcurrent clears on_phase, flipping to the low side
      s_nxt.drv.high_side_on = s_nxt.on_phase & ~pwm_reset;
      s_nxt.drv.low_side_on  = ~(s_nxt.on_phase & ~pwm_reset);
    end else begin
      s_nxt.drv.high_side_on = 1'b0;
      s_nxt.drv.low_side_on  = 1'b0;
    end
    s_nxt.drv.ss_charge         = (s_nxt.seq == BPS_SOFT_START);
    // off phase length is set by 30uA/1.5uA currents, about 12x
    s_nxt.drv.ss_discharge_slow = (s_nxt.seq == BPS_HICCUP_OFF);
    s_nxt.drv.ss_ground         = (s_nxt.seq == BPS_SS_GROUND);
    s_nxt.drv.output_discharge  = ~cond.enable &
                                  cond.vin_discharge_ok;

    // ******************************************************
    // power-good qualification
    // ******************************************************
    // open drain: the pin is only ever pulled low
    s_nxt.pg_pin_out = 1'b0;
    if (s_r.seq == BPS_OFF || s_r.seq == BPS_SOFT_START ||
        s_r.seq == BPS_HICCUP_OFF || s_r.seq == BPS_SS_GROUND) begin
      s_nxt.pg_down = 1'b1;
      s_nxt.pg_cnt  = '0;
    end else if (s_r.pg_down) begin
      if (!cond.out_in_window) begin
        s_nxt.pg_cnt = '0;
      end else if (s_r.pg_cnt >= 32'(PG_GOOD_CYCLES_P - 1)) begin
        s_nxt.pg_down = 1'b0;
        s_nxt.pg_cnt  = '0;
      end else begin
        s_nxt.pg_cnt = s_r.pg_cnt + 32'h1;
      end
    end else begin
      // glitches shorter than the bad time are filtered
      if (cond.out_in_window) begin
        s_nxt.pg_cnt = '0;
      end else if (s_r.pg_cnt >= 32'(PG_BAD_CYCLES)) begin
        s_nxt.pg_down = 1'b1;
        s_nxt.pg_cnt  = '0;
      end else begin
        s_nxt.pg_cnt = s_r.pg_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_r          <= '0;
      s_r.seq      <= BPS_OFF;
      s_r.pg_down  <= 1'b1;
      s_r.sync_out <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************************************************
  // outputs, all registered
  // ********************************************************
  assign sync_clock_out      = s_r.sync_out;
  assign power_good_pulldown = s_r.pg_down;
  assign power_good_pin_oe   = s_r.pg_down;
  assign power_good_pin_out  = s_r.pg_pin_out;
  assign cycle_start         = s_r.cycle;
  assign drive               = s_r.drv;

endmodule : bps_sequencer
`default_nettype wire

// ===== hdl/bps_sync.sv
`timescale 1ns/1ns
`default_nettype none
module bps_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } bps_sync_state_type;

  bps_sync_state_type state_r;
  bps_sync_state_type state_nxt;

  always_comb begin
    state_nxt        = state_r;
    state_nxt.stage1 = async_in;
    state_nxt.stage2 = state_r.stage1;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.stage2;

endmodule : bps_sync
`default_nettype wire

// ===== tb/bps_partner.sv
`timescale 1ns/1ns
`default_nettype none
module bps_partner (
  input  wire logic       clk_sys,
  input  wire logic [1:0] mode,
  input  wire logic       pg_oe,
  input  wire logic       pg_out,
  output var  logic       sync_clock_in,
  output var  logic       sync_detect,
  output wire logic       pg_level
);
  logic [6:0] ph_r;
  initial begin
    ph_r = 7'h00;
    sync_clock_in = 1'b0;
    sync_detect = 1'b0;
  end
  // 119 cycles a period: 2100 kHz, low phase 236 ns
  always @(posedge clk_sys) begin
    ph_r <= (ph_r == 7'h76) ? 7'h00 : ph_r + 7'h01;
    sync_clock_in <= (mode == 2'h1) ? (ph_r >= 7'h3b) : mode[1];
    sync_detect <= |mode;
  end
  // host side pull-up to the input supply
  assign pg_level = pg_oe ? pg_out : 1'b1;
endmodule : bps_partner
`default_nettype wire

// ===== tb/bps_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module bps_sequencer_bench;
  import bps_pkg::*;
  localparam int unsigned PGG = 50;
  logic          clk_sys, reset, pwm_reset, sco, pgd, oe, po, cs;
  logic          sync_clock_in, sync_detect, pg_level;
  logic [1:0]    mode;
  bps_cond_type  c;
  bps_drive_type d;
  int            mismatches, total_checks;
  bps_sequencer #(.PG_GOOD_CYCLES_P(PGG)) DUT (
    .clk_sys, .reset, .cond_in(c), .sync_clock_in, .sync_detect,
    .pwm_reset, .sync_clock_out(sco), .power_good_pulldown(pgd),
    .power_good_pin_oe(oe), .power_good_pin_out(po), .cycle_start(cs),
    .drive(d)
  );
  bps_partner u_far (
    .clk_sys, .mode, .pg_oe(oe), .pg_out(po), .sync_clock_in,
    .sync_detect, .pg_level
  );
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ********
  // helpers
  // ********
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  task cnt(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge clk_sys);
      k += int'(cs === 1'b1);
    end
  endtask : cnt
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // ********
  // scenarios
  // ********
  task t_disch;
    chk("pulldown", pgd, 8'h01);
    chk("pg_pin", pg_level, 8'h00);
    c.vin_discharge_ok <= 1'b1;
    wt(6);
    chk("discharge", d.output_discharge, 8'h01);
    c.vin_discharge_ok <= 1'b0;
    wt(6);
    chk("discharge", d.output_discharge, 8'h00);
    c.vin_discharge_ok <= 1'b1;
  endtask : t_disch
  task t_start;
    int k;
    mode <= 2'h1;
    c.vin_ok <= 1'b1;
    c.enable <= 1'b1;
    c.out_in_window <= 1'b1;
    wt(100);
    chk("ss_charge", d.ss_charge, 8'h01);
    chk("pulldown", pgd, 8'h01);
    c.ss_done <= 1'b1;
    wt(PGG - 10);
    chk("pulldown", pgd, 8'h01);
    wt(18);
    chk("pg_pin", pg_level, 8'h01);
    cnt(1190, k);
    chk("starts", 8'(k), 8'h0a);
    chk("gates", {d.high_side_on, d.low_side_on}, 8'h02);
    // a short return to the window must restart the bad count
    c.out_in_window <= 1'b0;
    wt(PG_BAD_CYCLES - 20);
    c.out_in_window <= 1'b1;
    wt(2);
    c.out_in_window <= 1'b0;
    wt(PG_BAD_CYCLES - 20);
    chk("pulldown", pgd, 8'h00);
    wt(30);
    chk("pulldown", pgd, 8'h01);
    c.out_in_window <= 1'b1;
    c.overvoltage <= 1'b1;
    wt(6);
    chk("ovp", {d.high_side_on, d.low_side_on}, 8'h01);
    c.overvoltage <= 1'b0;
  endtask : t_start
  task t_hiccup;
    c.overcurrent <= 1'b1;
    wt(400);
    chk("oc_reduced", d.oc_level_reduced, 8'h01);
    chk("gates", {d.high_side_on, d.low_side_on}, 8'h01);
    c.out_below_half <= 1'b1;
    wt(600);
    chk("oc_reduced", d.oc_level_reduced, 8'h01);
    chk("retry", d.ss_discharge_slow, 8'h00);
    c.enable <= 1'b0;
    wt(6);
    c.enable <= 1'b1;
    c.ss_done <= 1'b0;
    wt(1000);
    chk("retry", d.ss_discharge_slow, 8'h00);
    c.ss_done <= 1'b1;
    wt(960);
    chk("retry", d.ss_discharge_slow, 8'h01);
    c.ss_at_low <= 1'b1;
    wt(8);
    chk("ground", d.ss_ground, 8'h01);
    c.ss_at_low <= 1'b0;
    c.overcurrent <= 1'b0;
    c.ss_done <= 1'b0;
    wt(3570);
    chk("ground", d.ss_ground, 8'h01);
    wt(480);
    chk("ground", d.ss_ground, 8'h00);
    chk("ss_charge", d.ss_charge, 8'h01);
  endtask : t_hiccup
  task t_trip;
    int k;
    c.vin_ok <= 1'b0;
    wt(6);
    chk("gates", {d.high_side_on, d.low_side_on, d.converter_on}, 8'h00);
    c.vin_ok <= 1'b1;
    c.overtemp <= 1'b1;
    wt(12);
    chk("gates", {d.high_side_on, d.low_side_on, d.converter_on}, 8'h00);
    c.overtemp <= 1'b0;
    wt(10);
    chk("ss_charge", d.ss_charge, 8'h01);
    mode <= 2'h2;
    wt(20);
    cnt(500, k);
    chk("starts", 8'(k), 8'h00);
    chk("sync_out", sco, 8'h00);
    mode <= 2'h0;
    wt(20);
    cnt(2 * OSC_HALF_CYCLES * 10, k);
    chk("starts", 8'(k), 8'h0a);
  endtask : t_trip
  initial begin
    c = '0;
    reset = 1'b1;
    pwm_reset = 1'b0;
    mode = 2'h0;
    mismatches = 0;
    total_checks = 0;
    wt(3);
    reset <= 1'b0;
    wt(2);
    t_disch();
    t_start();
    t_hiccup();
    t_trip();
    final_report();
  end
  initial begin
    wt(30000);
    mismatches++;
    final_report();
  end
endmodule : bps_sequencer_bench
`default_nettype wire

// ===== tb/bps_sequencer_properties.sv
`timescale 1ns/1ns
`default_nettype none
module bps_sequencer_properties #(
  parameter int unsigned PG_GOOD_CYCLES_P = bps_pkg::PG_GOOD_CYCLES
) (
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire bps_pkg::bps_cond_type  cond_in,
  input wire logic                   sync_clock_in,
  input wire logic                   sync_detect,
  input wire logic                   pwm_reset,
  input wire logic                   sync_clock_out,
  input wire logic                   power_good_pulldown,
  input wire logic                   power_good_pin_oe,
  input wire logic                   power_good_pin_out,
  input wire logic                   cycle_start,
  input wire bps_pkg::bps_drive_type drive
);
  import bps_pkg::*;
  // ********
  // window run lengths seen at the pin
  // ********
  int unsigned out_n_r;
  int unsigned in_n_r;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_n_r <= 0;
      in_n_r <= 0;
    end else begin
      out_n_r <= cond_in.out_in_window ? 0 : out_n_r + 1;
      in_n_r <= cond_in.out_in_window ? in_n_r + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // margins of 4 cover the two synchroniser flops
  sequence s_held_high;
    (sync_detect && sync_clock_in) [*5];
  endsequence
  chk_pin_follows: assert property (power_good_pin_oe ==
    power_good_pulldown && !power_good_pin_out)
    else $error("pg pin not tied to pulldown");
  chk_pg_bad: assert property (out_n_r > PG_BAD_CYCLES + 4
    |-> power_good_pulldown) else $error("pg not pulled after bad");
  chk_pg_good: assert property ($fell(power_good_pulldown)
    |-> in_n_r >= PG_GOOD_CYCLES_P) else $error("pg released early");
  chk_ovp_gate: assert property (cond_in.overvoltage [*4]
    |=> !drive.high_side_on) else $error("high side on in ovp");
  chk_input_undervoltage_lock_off: assert property (!cond_in.vin_ok [*4] |=>
    !(drive.high_side_on || drive.low_side_on || drive.converter_on))
    else $error("switching under low input");
  chk_hot_off: assert property (cond_in.overtemp [*4] |=>
    !(drive.high_side_on || drive.low_side_on || drive.converter_on))
    else $error("switching while hot");
  chk_disch_on: assert property ((!cond_in.enable &&
    cond_in.vin_discharge_ok) [*4] |=> drive.output_discharge)
    else $error("discharge switch not on");
  chk_sync_inv: assert property (s_held_high |=>
    !sync_clock_out) else $error("sync out not inverted");
  chk_held_stop: assert property (s_held_high |=>
    !cycle_start) else $error("cycle start without fall");
  chk_start_pulse: assert property (cycle_start |=>
    !cycle_start) else $error("cycle start too long");
endmodule : bps_sequencer_properties
bind bps_sequencer bps_sequencer_properties #(
  .PG_GOOD_CYCLES_P(PG_GOOD_CYCLES_P)
) u_props (
  .clk_sys, .reset, .cond_in, .sync_clock_in, .sync_detect, .pwm_reset,
  .sync_clock_out, .power_good_pulldown, .power_good_pin_oe,
  .power_good_pin_out, .cycle_start, .drive
);
`default_nettype wire
